// ==== design/uct_pkg.sv ====
// Functional notes
// - Three independent 16-bit down counters, each with clock, gate and output.
// - Initial count is two to 65535; software keeps loads in range.
// - Software picks rising or falling clock edge per counter.
// - Internal clock rates 10 MHz, 1 MHz, 100 kHz or 10 kHz from crystal.
// - External clock pin may replace the internal clock per counter.
// - Counter output clocks next counter in order 0, 1, 2, 0.
// - Active-low gate polarity: count while gate low, hold while high.
// - Active-high gate polarity: count while gate high, hold while low.
// - Per-counter polarity bit sits in gate and clock control registers 0x20-0x24.
// - Software gate source is a register-driven level.
// - Previous-counter gate: 0 from 2, 1 from 0, 2 from 1.
// - External gate source uses each counter's own gate pin.
// - Counter wraps past zero; events equal loaded minus read value; the first edge after a load only loads the count and is not counted.
// - Software may read present count at any time.
// - Mode 3 gives square output at input clock divided by count, or by count minus one for odd counts.
// - Uncascaded rate generation reaches 5 MHz output.
// - Mode 1 gives one output pulse on the first gate trigger after each count load; later triggers are ignored.
// - One-shot pulse is active low, width is count times input period.
// - Analog pacing counter group is separate and not user visible.
package uct_pkg;
    // ----------------------------------------
    // Register word indices; the byte address is four times the index
    // ----------------------------------------
    localparam logic [7:0] ADDR_COUNT0 = 8'h18;
    localparam logic [7:0] ADDR_COUNT1 = 8'h1A;
    localparam logic [7:0] ADDR_COUNT2 = 8'h1C;
    localparam logic [7:0] ADDR_MODE = 8'h1E;
    localparam logic [7:0] ADDR_GATE0 = 8'h20;
    localparam logic [7:0] ADDR_GATE1 = 8'h22;
    localparam logic [7:0] ADDR_GATE2 = 8'h24;
    localparam logic [7:0] ADDR_RATE = 8'h26;
    // ----------------------------------------
    // Gate and clock control fields
    // ----------------------------------------
    localparam int CSRC_LSB = 0;
    localparam int EDGE_BIT = 2;
    localparam int SW_GATE_BIT = 3;
    localparam int GSRC_LSB = 4;
    localparam int POL_BIT = 6;
    localparam int SW_CLK_BIT = 7;
    localparam int STAT_GATE_BIT = 8;
    localparam int STAT_OUT_BIT = 9;
    localparam int STAT_CLK_BIT = 10;
    localparam logic [6:0] GATE_CTRL_RESET = 7'h00;
    // ----------------------------------------
    // Mode word fields
    // ----------------------------------------
    localparam int SEL_LSB = 6;
    localparam int MODE_LSB = 1;
    localparam logic [1:0] SEL_LATCH_NONE = 2'h3;
    // ----------------------------------------
    // Rate generation
    // ----------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int RATE0_HZ = 10_000_000;
    localparam int RATE1_HZ = 1_000_000;
    localparam int RATE2_HZ = 100_000;
    localparam int RATE3_HZ = 10_000;
    localparam int DIV0 = CLK_HZ / RATE0_HZ;
    localparam int DIV1 = CLK_HZ / RATE1_HZ;
    localparam int DIV2 = CLK_HZ / RATE2_HZ;
    localparam int DIV3 = CLK_HZ / RATE3_HZ;
    localparam int NUM_COUNTERS = 3;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        uct_csrc_internal = 2'b00,
        uct_csrc_external = 2'b01,
        uct_csrc_cascade = 2'b10,
        uct_csrc_software = 2'b11
    } uct_csrc_type;

    typedef enum logic [1:0] {
        uct_gsrc_software = 2'b00,
        uct_gsrc_previous = 2'b01,
        uct_gsrc_external = 2'b10,
        uct_gsrc_always = 2'b11
    } uct_gsrc_type;

    typedef struct packed {
        logic pol_high;
        uct_gsrc_type gsrc;
        logic sw_gate;
        logic edge_fall;
        uct_csrc_type csrc;
    } uct_gate_ctrl_type;

    typedef struct packed {
        logic write_low;
        logic write_high;
        logic latch;
        logic set_mode;
        logic [2:0] mode;
        logic [1:0] access;
        logic [7:0] data;
    } uct_cmd_type;
endpackage : uct_pkg

// ==== design/uct_rate_gen.sv ====
module uct_rate_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Rate select and tick
    input wire logic [1:0] rate_sel,
    output logic tick
);
    logic [15:0] div_count;
    logic [15:0] div_limit;

    // ----------------------------------------
    // Crystal divider
    // ----------------------------------------
    // rate choice
    always_comb begin
        case (rate_sel)
            2'h0: div_limit = 16'(uct_pkg::DIV0 - 1);
            2'h1: div_limit = 16'(uct_pkg::DIV1 - 1);
            2'h2: div_limit = 16'(uct_pkg::DIV2 - 1);
            default: div_limit = 16'(uct_pkg::DIV3 - 1);
        endcase
    end

    // The tick is one pclk wide; the counter sees it as a rising then falling edge pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 16'h0000;
            tick <= 1'b0;
        end else if (div_count >= div_limit) begin
            div_count <= 16'h0000;
            tick <= 1'b1;
        end else begin
            div_count <= div_count + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : uct_rate_gen

// ==== design/uct_channel.sv ====
module uct_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commands
    input wire uct_pkg::uct_cmd_type cmd,
    // Qualified clock edge and gate level
    input wire logic clk_edge,
    input wire logic gate_level,
    // Status
    output logic out_level,
    output logic [15:0] count_now,
    output logic [15:0] latched,
    output logic latch_valid
);
    typedef enum logic [1:0] {
        uct_st_idle = 2'b00,
        uct_st_wait_high = 2'b01,
        uct_st_armed = 2'b10,
        uct_st_run = 2'b11
    } uct_ch_state_type;

    uct_ch_state_type state;
    logic [2:0] mode;
    logic [15:0] initial_count;
    logic [7:0] low_hold;
    logic gate_prev;
    logic trigger;
    logic [15:0] reload;

    function automatic logic [15:0] uct_dec(input logic [15:0] v, input logic [15:0] step);
        uct_dec = v - step;
    endfunction : uct_dec

    assign trigger = gate_level && !gate_prev;
    // Mode 3 steps by two; odd counts reload the even count below for both halves
    assign reload = {initial_count[15:1], 1'b0};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_prev <= 1'b0;
        end else begin
            gate_prev <= gate_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= 3'h0;
            initial_count <= uct_pkg::COUNT_RESET;
            low_hold <= 8'h00;
            state <= uct_st_idle;
        end else if (cmd.set_mode) begin
            mode <= cmd.mode;
            state <= uct_st_idle;
        end else if (cmd.write_low) begin
            low_hold <= cmd.data;
            if (cmd.access == 2'h1) begin
                initial_count <= {8'h00, cmd.data};
                state <= uct_st_armed;
            end
        end else if (cmd.write_high) begin
            // counts below two are not guarded; software keeps loads in range
            initial_count <= (cmd.access == 2'h3) ? {cmd.data, low_hold} : {cmd.data, 8'h00};
            state <= uct_st_armed;
        end else begin
            case (state)
                uct_st_armed: begin
                    // mode 1 waits for a gate trigger
                    if (mode == 3'h1 ? trigger : clk_edge) begin
                        state <= (mode == 3'h1) ? uct_st_wait_high : uct_st_run;
                    end
                end
                uct_st_wait_high: begin
                    if (clk_edge) begin
                        state <= uct_st_run;
                    end
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Count and output
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_now <= uct_pkg::COUNT_RESET;
            out_level <= 1'b1;
        end else if (cmd.set_mode) begin
            out_level <= (cmd.mode[1:0] == 2'h0) ? 1'b0 : 1'b1;
        end else if ((state == uct_st_armed) && (mode != 3'h1) && clk_edge) begin
            count_now <= (mode[1:0] == 2'h3) ? reload : initial_count;
            if (mode[1:0] == 2'h0) begin
                out_level <= 1'b0;
            end
        end else if ((state == uct_st_wait_high) && clk_edge) begin
            count_now <= initial_count;
            out_level <= 1'b0;
        end else if (state == uct_st_run) begin
            case (mode[1:0])
                2'h0: begin
                    // hold while gate inactive; wraps past zero
                    if (clk_edge && gate_level) begin
                        count_now <= uct_dec(count_now, 16'h0001);
                        if (count_now == 16'h0001) begin
                            out_level <= 1'b1;
                        end
                    end
                end
                2'h1: begin
                    if (clk_edge) begin
                        count_now <= uct_dec(count_now, 16'h0001);
                        if (count_now == 16'h0001) begin
                            out_level <= 1'b1;
                        end
                    end
                end
                2'h3: begin
                    // square wave divide by count; a count of two halves the input rate
                    if (!gate_level) begin
                        out_level <= 1'b1;
                    end else if (clk_edge) begin
                        if (count_now <= 16'h0002) begin
                            count_now <= reload;
                            out_level <= !out_level;
                        end else begin
                            count_now <= uct_dec(count_now, 16'h0002);
                        end
                    end
                end
                default: begin
                    if (clk_edge && gate_level) begin
                        count_now <= uct_dec(count_now, 16'h0001);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched <= uct_pkg::COUNT_RESET;
            latch_valid <= 1'b0;
        end else if (cmd.latch && !latch_valid) begin
            latched <= count_now;
            latch_valid <= 1'b1;
        end else if (cmd.set_mode) begin
            latch_valid <= 1'b0;
        end
    end
endmodule : uct_channel

// ==== design/uct_top.sv ====
module uct_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Field pins
    input wire logic [2:0] counter_clock_pin,
    input wire logic [2:0] counter_gate_pin,
    output logic [2:0] counter_out
);
    // only the user group is built here
    uct_pkg::uct_gate_ctrl_type gate_ctrl [3];
    uct_pkg::uct_cmd_type cmd [3];
    logic [1:0] rate_sel;
    logic [2:0] clk_sync1, clk_sync2, gate_sync1, gate_sync2;
    logic [2:0] ch_out, raw_clk, clk_prev, clk_edge, gate_raw, gate_level;
    logic [15:0] count_now [3];
    logic [15:0] latched [3];
    logic [2:0] latch_valid;
    logic [2:0] read_high;
    logic [7:0] word_idx;
    logic [1:0] access [3];
    logic int_tick;
    logic access_phase;
    logic wr, rd;
    logic [1:0] cnt_idx;
    logic cnt_hit, gate_hit;

    function automatic logic [1:0] uct_prev(input int i);
        uct_prev = (i == 0) ? 2'd2 : 2'(i - 1);
    endfunction : uct_prev

    assign access_phase = psel && penable;
    assign wr = access_phase && pwrite;
    assign rd = access_phase && !pwrite;
    // One word per register; a misaligned byte address matches no register
    assign word_idx = (paddr[1:0] == 2'b00) ? {2'b00, paddr[7:2]} : 8'hFF;
    assign cnt_hit = (word_idx == uct_pkg::ADDR_COUNT0) || (word_idx == uct_pkg::ADDR_COUNT1)
        || (word_idx == uct_pkg::ADDR_COUNT2);
    assign gate_hit = (word_idx == uct_pkg::ADDR_GATE0) || (word_idx == uct_pkg::ADDR_GATE1)
        || (word_idx == uct_pkg::ADDR_GATE2);
    // Counter and gate registers select their channel by the same two index bits
    assign cnt_idx = word_idx[2:1];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync1 <= 3'h0;
            clk_sync2 <= 3'h0;
            gate_sync1 <= 3'h0;
            gate_sync2 <= 3'h0;
        end else begin
            clk_sync1 <= counter_clock_pin;
            clk_sync2 <= clk_sync1;
            gate_sync1 <= counter_gate_pin;
            gate_sync2 <= gate_sync1;
        end
    end

    uct_rate_gen u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .rate_sel(rate_sel),
        .tick(int_tick)
    );

    // ----------------------------------------
    // Clock and gate routing
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < uct_pkg::NUM_COUNTERS; i++) begin
            case (gate_ctrl[i].csrc)
                uct_pkg::uct_csrc_internal: raw_clk[i] = int_tick;
                uct_pkg::uct_csrc_external: raw_clk[i] = clk_sync2[i];
                uct_pkg::uct_csrc_cascade: raw_clk[i] = ch_out[uct_prev(i)];
                default: raw_clk[i] = 1'b0;
            endcase
            case (gate_ctrl[i].gsrc)
                uct_pkg::uct_gsrc_software: gate_raw[i] = gate_ctrl[i].sw_gate;
                uct_pkg::uct_gsrc_previous: gate_raw[i] = ch_out[uct_prev(i)];
                uct_pkg::uct_gsrc_external: gate_raw[i] = gate_sync2[i];
                default: gate_raw[i] = gate_ctrl[i].pol_high;
            endcase
            gate_level[i] = gate_ctrl[i].pol_high ? gate_raw[i] : !gate_raw[i];
            clk_edge[i] = gate_ctrl[i].edge_fall ? (clk_prev[i] && !raw_clk[i]) : (!clk_prev[i] && raw_clk[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev <= 3'h0;
            counter_out <= 3'h7;
        end else begin
            clk_prev <= raw_clk;
            counter_out <= ch_out;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < uct_pkg::NUM_COUNTERS; i++) begin
                gate_ctrl[i] <= uct_pkg::GATE_CTRL_RESET;
            end
            rate_sel <= 2'h0;
        end else if (wr && gate_hit) begin
            gate_ctrl[cnt_idx] <= pwdata[6:0];
        end else if (wr && (word_idx == uct_pkg::ADDR_RATE)) begin
            rate_sel <= pwdata[1:0];
        end
    end

    always_comb begin
        for (int i = 0; i < uct_pkg::NUM_COUNTERS; i++) begin
            cmd[i] = '0;
            cmd[i].access = access[i];
            cmd[i].data = pwdata[7:0];
            cmd[i].mode = pwdata[3:1];
        end
        if (wr && (word_idx == uct_pkg::ADDR_MODE) && (pwdata[7:6] != uct_pkg::SEL_LATCH_NONE)) begin
            if (pwdata[5:4] == 2'h0) begin
                cmd[pwdata[7:6]].latch = 1'b1;
            end else begin
                cmd[pwdata[7:6]].set_mode = 1'b1;
            end
        end
        if (wr && cnt_hit) begin
            if (access[cnt_idx] == 2'h2 || (access[cnt_idx] == 2'h3 && read_high[cnt_idx])) begin
                cmd[cnt_idx].write_high = 1'b1;
            end else begin
                cmd[cnt_idx].write_low = 1'b1;
            end
        end
    end

    // Byte toggle shared by reads and writes of each counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_high <= 3'h0;
            for (int i = 0; i < uct_pkg::NUM_COUNTERS; i++) begin
                access[i] <= 2'h3;
            end
        end else begin
            for (int i = 0; i < uct_pkg::NUM_COUNTERS; i++) begin
                if (cmd[i].set_mode) begin
                    access[i] <= pwdata[5:4];
                    read_high[i] <= 1'b0;
                end else if (access_phase && cnt_hit && (cnt_idx == 2'(i)) && (access[i] == 2'h3)) begin
                    read_high[i] <= !read_high[i];
                end
            end
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_ch
        uct_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .cmd(cmd[g]),
            .clk_edge(clk_edge[g]),
            .gate_level(gate_level[g]),
            .out_level(ch_out[g]),
            .count_now(count_now[g]),
            .latched(latched[g]),
            .latch_valid(latch_valid[g])
        );
    end

    // ----------------------------------------
    // APB read data
    // ----------------------------------------
    // count readback any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(cnt_hit || gate_hit || word_idx == uct_pkg::ADDR_MODE
                || word_idx == uct_pkg::ADDR_RATE);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite && cnt_hit) begin
                prdata[7:0] <= (read_high[cnt_idx] || access[cnt_idx] == 2'h2)
                    ? (latch_valid[cnt_idx] ? latched[cnt_idx][15:8] : count_now[cnt_idx][15:8])
                    : (latch_valid[cnt_idx] ? latched[cnt_idx][7:0] : count_now[cnt_idx][7:0]);
            end else if (psel && !penable && !pwrite && gate_hit) begin
                prdata[6:0] <= gate_ctrl[cnt_idx];
                prdata[uct_pkg::STAT_GATE_BIT] <= gate_level[cnt_idx];
                prdata[uct_pkg::STAT_OUT_BIT] <= ch_out[cnt_idx];
                prdata[uct_pkg::STAT_CLK_BIT] <= raw_clk[cnt_idx];
            end else if (psel && !penable && !pwrite && word_idx == uct_pkg::ADDR_RATE) begin
                prdata[1:0] <= rate_sel;
            end
        end
    end
endmodule : uct_top

// ==== dv/uct_monitor.sv ====
module uct_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Field pins
    input wire logic [2:0] counter_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mapped;
    // Registers sit one per word: aligned byte address over four is the index
    assign mapped = (paddr[1:0] == 2'b00) && ({2'b00, paddr[7:2]} inside {uct_pkg::ADDR_COUNT0,
        uct_pkg::ADDR_COUNT1, uct_pkg::ADDR_COUNT2, uct_pkg::ADDR_MODE, uct_pkg::ADDR_GATE0,
        uct_pkg::ADDR_GATE1, uct_pkg::ADDR_GATE2, uct_pkg::ADDR_RATE});
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    ready_after_setup_a:
        assert property (setup_s |=> pready) else $error("no ready after setup");
    ready_in_access_a:
        assert property (pready |-> access_s) else $error("ready outside access phase");
    ready_single_a:
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    ready_after_one_a:
        assert property (pready |-> $past(psel && !penable)) else $error("ready not one cycle after setup");
    err_unmapped_a:
        assert property (pready && !mapped |-> pslverr) else $error("unmapped access not refused");
    no_err_mapped_a:
        assert property (pready && mapped |-> !pslverr) else $error("mapped access refused");
    bad_read_zero_a:
        assert property (pready && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
    out_idle_high_a:
        assert property ($rose(presetn) |-> counter_out == 3'h7) else $error("outputs not high after reset");
endmodule : uct_monitor

bind uct_top uct_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_out(counter_out));

// ==== dv/uct_field_model.sv ====
module uct_field_model (
    // Clock
    input wire logic pclk,
    // Field pins
    output logic [2:0] counter_clock_pin,
    output logic [2:0] counter_gate_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock pins stand still low between bursts
    initial begin
        counter_clock_pin = 3'h0;
        counter_gate_pin = 3'h0;
    end
    // external clock burst, period eight cycles
    task automatic pulses(input int idx, input int n);
        repeat (n) begin
            @(posedge pclk);
            counter_clock_pin[idx] <= 1'b1;
            repeat (4) @(posedge pclk);
            counter_clock_pin[idx] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulses
    task automatic gate(input int idx, input logic lvl);
        @(posedge pclk);
        counter_gate_pin[idx] <= lvl;
    endtask : gate
endmodule : uct_field_model

// ==== dv/uct_top_test.sv ====
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end
module uct_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [2:0] counter_clock_pin, counter_gate_pin, counter_out;
    logic [15:0] cnt;
    int num_errors = 0, total_checks = 0, cycles = 0, falls = 0, w = 0;
    time t0;
    int divs[4] = '{uct_pkg::DIV0, uct_pkg::DIV1, uct_pkg::DIV2, uct_pkg::DIV3};
    uct_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .counter_clock_pin, .counter_gate_pin, .counter_out);
    uct_field_model fld (.pclk, .counter_clock_pin, .counter_gate_pin);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(negedge counter_out[1]) falls++;
    // A hang counts as a mismatch
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_count(input logic [7:0] a);
        apb(1'b0, a, 8'h00);
        cnt[7:0] = rdv[7:0];
        apb(1'b0, a, 8'h00);
        cnt[15:8] = rdv[7:0];
    endtask : rd_count
    // Byte address of a register word index
    function automatic logic [7:0] ba(input int idx);
        return 8'(idx * 4);
    endfunction : ba
    function automatic logic [7:0] ga(input int i);
        return ba(uct_pkg::ADDR_GATE0 + 2 * i);
    endfunction : ga
    function automatic logic [7:0] gc(uct_pkg::uct_csrc_type cs, logic sg, uct_pkg::uct_gsrc_type gs);
        uct_pkg::uct_gate_ctrl_type g;
        g = '{pol_high: 1'b1, gsrc: gs, sw_gate: sg, edge_fall: 1'b0, csrc: cs};
        return {1'b0, g};
    endfunction : gc
    // Mode word then low byte, high byte
    task automatic load(input int i, input logic [2:0] m, input logic [15:0] v);
        apb(1'b1, ba(uct_pkg::ADDR_MODE), {2'(i), 2'h3, m, 1'b0});
        apb(1'b1, ba(uct_pkg::ADDR_COUNT0 + 2 * i), v[7:0]);
        apb(1'b1, ba(uct_pkg::ADDR_COUNT0 + 2 * i), v[15:8]);
    endtask : load
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("idle outputs", 3'h7, counter_out)
        apb(1'b0, ga(0), 8'h00);
        `CHK("gate ctrl reset", 7'h00, rdv[6:0])
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ga(i), 8'h5A);
            apb(1'b0, ga(i), 8'h00);
            `CHK("gate ctrl", 7'h5A, rdv[6:0])
        end
        apb(1'b0, 8'h00, 8'h00);
        `CHK("unmapped read", 33'h100000000, {errv, rdv})
        apb(1'b1, 8'h04, 8'h11);
        `CHK("unmapped write", 1'b1, errv)
        $display("register test done");
        apb(1'b1, ga(0), gc(uct_pkg::uct_csrc_external, 1'b0, uct_pkg::uct_gsrc_software));
        load(0, 3'd0, 16'hFFFF);
        apb(1'b1, ga(0), gc(uct_pkg::uct_csrc_external, 1'b1, uct_pkg::uct_gsrc_software));
        fld.pulses(0, 10);
        apb(1'b1, ga(0), gc(uct_pkg::uct_csrc_external, 1'b0, uct_pkg::uct_gsrc_software));
        rd_count(ba(uct_pkg::ADDR_COUNT0));
        `CHK("event count", 16'hFFF6, cnt)
        fld.pulses(0, 5);
        rd_count(ba(uct_pkg::ADDR_COUNT0));
        `CHK("held count", 16'hFFF6, cnt)
        // Latch the count, then count on falling edges only
        apb(1'b1, ba(uct_pkg::ADDR_MODE), 8'h00);
        apb(1'b1, ga(0), 8'h4D);
        fld.pulses(0, 3);
        rd_count(ba(uct_pkg::ADDR_COUNT0));
        `CHK("latched count", 16'hFFF6, cnt)
        apb(1'b1, ba(uct_pkg::ADDR_MODE), 8'h30);
        rd_count(ba(uct_pkg::ADDR_COUNT0));
        `CHK("falling edge count", 16'hFFF3, cnt)
        $display("event test done");
        apb(1'b1, ga(1), gc(uct_pkg::uct_csrc_external, 1'b0, uct_pkg::uct_gsrc_external));
        load(1, 3'd1, 16'd5);
        falls = 0;
        fld.gate(1, 1'b1);
        fork
            fld.pulses(1, 12);
            begin
                @(negedge counter_out[1]);
                t0 = $time;
                @(posedge counter_out[1]);
                w = int'(($time - t0) / 10);
            end
        join
        `CHK("pulse width", 40, w)
        `CHK("pulse count", 1, falls)
        $display("one shot test done");
        apb(1'b1, ga(2), gc(uct_pkg::uct_csrc_internal, 1'b0, uct_pkg::uct_gsrc_always));
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, ba(uct_pkg::ADDR_RATE), 8'(r));
            load(2, 3'd3, 16'd2);
            @(posedge counter_out[2]);
            t0 = $time;
            @(posedge counter_out[2]);
            `CHK("rate period", 2 * divs[r], int'(($time - t0) / 10))
        end
        $display("rate test done");
        tally_and_finish();
    end
endmodule : uct_top_test
